// ### hw/vipl_top.sv
// Interrupt acceptance, masking, prioritisation and vectoring.
// How it works
// R1: Watchdog non-maskable request is taken regardless of masks or global accept.
// R2: Non-maskable request sits outside the priority scheme and beats all maskables.
// R3: Standby release rises whenever a non-maskable or unmasked maskable request is pending.
// R4: A masked source is never offered to the core.
// R5: Simultaneous maskable requests are served lowest level first, 0 to 15.
// R6: Watchdog overflow is the only non-maskable source, vector 0004H.
// R7: In interval mode watchdog overflow becomes maskable level 0.
// R8: Only one watchdog form is active at a time.
// R9: Pin edge requests 0 to 3 take levels 1 to 4, vectors 0006H-000CH.
// R10: Serial receive done and serial A clocked transfer merge into level 5, 0010H.
// R11: Levels 6 to 14 map to vectors 0012H to 0022H in steps of two.
// R12: Level 11 carries timer C match, or cascaded 16-bit match.
// R13: Key return is level 15, vector 0024H.
// R14: Vectors 000EH and 0026H to 002CH are never issued.
// R15: Sixteen maskable sources plus one non-maskable watchdog source.
// R16: Each maskable source has pending and mask flags; a global accept flag gates maskables.
// R17: Pending flags hold until acknowledged or cleared by software.
// R18: The core fetches its handler from the issued vector on acknowledge.
`timescale 1ns/10ps
`default_nettype none
module vipl_top
  import vipl_pkg::*;
(
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic WDT_INTERVAL_MODE_I,
  input wire logic WATCHDOG_OVERFLOW_IRQ_I,
  input wire logic PIN_EDGE_IRQ_0_I,
  input wire logic PIN_EDGE_IRQ_1_I,
  input wire logic PIN_EDGE_IRQ_2_I,
  input wire logic PIN_EDGE_IRQ_3_I,
  input wire logic SERIAL_RX_DONE_IRQ_I,
  input wire logic SERIAL_A_CLOCKED_XFER_IRQ_I,
  input wire logic SERIAL_B_CLOCKED_XFER_IRQ_I,
  input wire logic SERIAL_TX_DONE_IRQ_I,
  input wire logic WATCH_INTERVAL_IRQ_I,
  input wire logic TIMER_A_MATCH_IRQ_I,
  input wire logic TIMER_B_MATCH_IRQ_I,
  input wire logic TIMER_C_MATCH_IRQ_I,
  input wire logic CONVERTER_DONE_IRQ_I,
  input wire logic WATCH_OVERFLOW_IRQ_I,
  input wire logic KEY_RETURN_IRQ_I,
  input wire logic TIMER_D_MATCH_IRQ_I,
  input wire logic MASK_WR_I,
  input wire logic [NUM_SRC-1:0] MASK_DATA_I,
  input wire logic [NUM_SRC-1:0] PEND_CLR_I,
  input wire logic ACCEPT_SET_I,
  input wire logic ACCEPT_CLR_I,
  input wire logic ACK_I,
  output logic NMI_REQ_O,
  output logic IRQ_REQ_O,
  output logic [VEC_W-1:0] VECTOR_O,
  output logic [PRIO_W-1:0] PRIORITY_O,
  output logic STBY_RELEASE_O,
  output logic [NUM_SRC-1:0] PENDING_O,
  output logic [NUM_SRC-1:0] SOURCE_MASK_FLAG_O,
  output logic GLOBAL_ACCEPT_FLAG_O
);

  // ---------------------------------------------------------------
  // State and next values
  // ---------------------------------------------------------------
  logic [NUM_SRC-1:0] pend_reg;
  logic [NUM_SRC-1:0] pend_next;
  logic [NUM_SRC-1:0] mask_reg;
  logic [NUM_SRC-1:0] mask_next;
  logic accept_reg;
  logic accept_next;
  logic nmi_reg;
  logic nmi_next;
  logic [NUM_SRC-1:0] src_set;
  logic [NUM_SRC-1:0] clr_vec;
  logic [NUM_SRC-1:0] hold_vec;
  logic [NUM_SRC-1:0] offer_vec;
  logic nmi_set;
  logic ack_nmi;
  logic ack_irq;
  logic pick_hit;
  logic [PRIO_W-1:0] pick_idx;

  // ---------------------------------------------------------------
  // Source mapping
  // ---------------------------------------------------------------
  // The watchdog feeds exactly one of the two forms, chosen by its mode.
  assign nmi_set = WATCHDOG_OVERFLOW_IRQ_I & ~WDT_INTERVAL_MODE_I; // [R6] [R8]

  always_comb begin
    src_set = '0; // [R15]
    src_set[SRC_WDT] = WATCHDOG_OVERFLOW_IRQ_I & WDT_INTERVAL_MODE_I; // [R7] [R8]
    src_set[SRC_PIN0] = PIN_EDGE_IRQ_0_I; // [R9]
    src_set[SRC_PIN1] = PIN_EDGE_IRQ_1_I; // [R9]
    src_set[SRC_PIN2] = PIN_EDGE_IRQ_2_I; // [R9]
    src_set[SRC_PIN3] = PIN_EDGE_IRQ_3_I; // [R9]
    src_set[SRC_SERIAL_A] = SERIAL_RX_DONE_IRQ_I | SERIAL_A_CLOCKED_XFER_IRQ_I; // [R10]
    src_set[SRC_SERIAL_B] = SERIAL_B_CLOCKED_XFER_IRQ_I; // [R11]
    src_set[SRC_SERIAL_TX] = SERIAL_TX_DONE_IRQ_I; // [R11]
    src_set[SRC_WATCH_INT] = WATCH_INTERVAL_IRQ_I; // [R11]
    src_set[SRC_TIMER_A] = TIMER_A_MATCH_IRQ_I; // [R11]
    src_set[SRC_TIMER_B] = TIMER_B_MATCH_IRQ_I; // [R11]
    // The timer block drives this line for both its 8-bit and cascaded match.
    src_set[SRC_TIMER_C] = TIMER_C_MATCH_IRQ_I; // [R12]
    src_set[SRC_TIMER_D] = TIMER_D_MATCH_IRQ_I; // [R11]
    src_set[SRC_CONVERTER] = CONVERTER_DONE_IRQ_I; // [R11]
    src_set[SRC_WATCH_OVF] = WATCH_OVERFLOW_IRQ_I; // [R11]
    src_set[SRC_KEY_RETURN] = KEY_RETURN_IRQ_I; // [R13]
  end

  // ---------------------------------------------------------------
  // Acknowledge and next-state logic
  // ---------------------------------------------------------------
  // An acknowledge applies to what is shown on the outputs this cycle.
  assign ack_nmi = ACK_I & NMI_REQ_O;
  assign ack_irq = ACK_I & IRQ_REQ_O;

  always_comb begin
    clr_vec = PEND_CLR_I;
    if (ack_irq) begin
      clr_vec[PRIORITY_O] = 1'b1;
    end
  end

  assign hold_vec = pend_reg & ~clr_vec;
  // A new event in the clearing cycle survives.
  assign pend_next = hold_vec | src_set; // [R16] [R17]
  assign mask_next = MASK_WR_I ? MASK_DATA_I : mask_reg; // [R16]
  assign accept_next = ACCEPT_SET_I | (accept_reg & ~ACCEPT_CLR_I & ~ack_irq); // [R16]
  assign nmi_next = nmi_set | (nmi_reg & ~ack_nmi); // [R1]
  assign offer_vec = pend_next & ~mask_next & {NUM_SRC{accept_next}}; // [R4] [R16]

  vipl_prio_pick u_pick (
    .req_i(offer_vec),
    .hit_o(pick_hit),
    .idx_o(pick_idx)
  ); // [R5]

  // ---------------------------------------------------------------
  // Flag registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      pend_reg <= PEND_RESET;
      nmi_reg <= 1'b0;
    end else begin
      pend_reg <= pend_next;
      nmi_reg <= nmi_next;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      mask_reg <= MASK_RESET;
      accept_reg <= ACCEPT_RESET;
    end else begin
      mask_reg <= mask_next;
      accept_reg <= accept_next;
    end
  end

  // ---------------------------------------------------------------
  // Core-facing outputs
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      NMI_REQ_O <= 1'b0;
      IRQ_REQ_O <= 1'b0;
      VECTOR_O <= 16'h0000;
      PRIORITY_O <= 4'h0;
      STBY_RELEASE_O <= 1'b0;
    end else begin
      NMI_REQ_O <= nmi_next; // [R1]
      IRQ_REQ_O <= pick_hit & ~nmi_next; // [R2]
      VECTOR_O <= nmi_next ? NMI_VECTOR : VEC_TABLE[pick_idx]; // [R2] [R6] [R14] [R18]
      PRIORITY_O <= pick_idx; // [R5]
      STBY_RELEASE_O <= nmi_next | (|(pend_next & ~mask_next)); // [R3]
    end
  end

  assign PENDING_O = pend_reg;
  assign SOURCE_MASK_FLAG_O = mask_reg;
  assign GLOBAL_ACCEPT_FLAG_O = accept_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);

  chk_nmi_taken: assert property ( // [R1]
    WATCHDOG_OVERFLOW_IRQ_I && !WDT_INTERVAL_MODE_I |=> NMI_REQ_O && nmi_reg)
    else $error("Non-maskable watchdog request was not raised.");

  chk_nmi_ranks_top: assert property ( // [R2]
    NMI_REQ_O |-> !IRQ_REQ_O && VECTOR_O == NMI_VECTOR)
    else $error("Maskable request shown while non-maskable pending.");

  chk_stby_release: assert property ( // [R3]
    NMI_REQ_O || IRQ_REQ_O |-> STBY_RELEASE_O)
    else $error("Request pending without standby release.");

  chk_mask_gate: assert property ( // [R4]
    IRQ_REQ_O |-> !mask_reg[PRIORITY_O] && accept_reg && pend_reg[PRIORITY_O])
    else $error("Masked or unaccepted source offered to core.");

  chk_prio_order: assert property ( // [R5]
    IRQ_REQ_O |-> (pend_reg & ~mask_reg & ((16'h0001 << PRIORITY_O) - 16'h0001)) == 16'h0000)
    else $error("Lower level pending source was passed over.");

  chk_wdt_maskable: assert property ( // [R7]
    WATCHDOG_OVERFLOW_IRQ_I && WDT_INTERVAL_MODE_I |=> pend_reg[SRC_WDT])
    else $error("Interval-mode watchdog did not set level 0.");

  chk_wdt_one_form: assert property ( // [R8]
    $rose(nmi_reg) |-> $past(WDT_INTERVAL_MODE_I) == 1'b0)
    else $error("Non-maskable watchdog raised in interval mode.");

  chk_vector_map: assert property ( // [R9] [R11] [R13]
    IRQ_REQ_O |-> VECTOR_O == VEC_TABLE[PRIORITY_O])
    else $error("Issued vector does not match source level.");

  chk_unused_vecs: assert property ( // [R14]
    NMI_REQ_O || IRQ_REQ_O |-> VECTOR_O != VEC_HOLE &&
      (VECTOR_O < VEC_UNUSED_LO || VECTOR_O > VEC_UNUSED_HI))
    else $error("Vector with no source was issued.");

  chk_pend_hold: assert property ( // [R17]
    ##1 ($past(hold_vec) & ~pend_reg) == 16'h0000)
    else $error("Pending flag dropped without acknowledge or clear.");

endmodule // vipl_top
`default_nettype wire

// ### include/vipl_pkg.sv
// Constants shared by the vectored interrupt priority logic.
`default_nettype none
package vipl_pkg;

  // ---------------------------------------------------------------
  // Source numbering and widths
  // ---------------------------------------------------------------
  localparam int NUM_SRC = 16;
  localparam int PRIO_W = 4;
  localparam int VEC_W = 16;

  localparam logic [PRIO_W-1:0] SRC_WDT = 4'h0;
  localparam logic [PRIO_W-1:0] SRC_PIN0 = 4'h1;
  localparam logic [PRIO_W-1:0] SRC_PIN1 = 4'h2;
  localparam logic [PRIO_W-1:0] SRC_PIN2 = 4'h3;
  localparam logic [PRIO_W-1:0] SRC_PIN3 = 4'h4;
  localparam logic [PRIO_W-1:0] SRC_SERIAL_A = 4'h5;
  localparam logic [PRIO_W-1:0] SRC_SERIAL_B = 4'h6;
  localparam logic [PRIO_W-1:0] SRC_SERIAL_TX = 4'h7;
  localparam logic [PRIO_W-1:0] SRC_WATCH_INT = 4'h8;
  localparam logic [PRIO_W-1:0] SRC_TIMER_A = 4'h9;
  localparam logic [PRIO_W-1:0] SRC_TIMER_B = 4'hA;
  localparam logic [PRIO_W-1:0] SRC_TIMER_C = 4'hB;
  localparam logic [PRIO_W-1:0] SRC_TIMER_D = 4'hC;
  localparam logic [PRIO_W-1:0] SRC_CONVERTER = 4'hD;
  localparam logic [PRIO_W-1:0] SRC_WATCH_OVF = 4'hE;
  localparam logic [PRIO_W-1:0] SRC_KEY_RETURN = 4'hF;

  // ---------------------------------------------------------------
  // Vector table
  // ---------------------------------------------------------------
  localparam logic [VEC_W-1:0] NMI_VECTOR = 16'h0004;
  localparam logic [VEC_W-1:0] VEC_TABLE [NUM_SRC] = '{
    16'h0004, 16'h0006, 16'h0008, 16'h000A, 16'h000C, 16'h0010, 16'h0012, 16'h0014,
    16'h0016, 16'h0018, 16'h001A, 16'h001C, 16'h001E, 16'h0020, 16'h0022, 16'h0024
  };
  localparam logic [VEC_W-1:0] VEC_HOLE = 16'h000E;
  localparam logic [VEC_W-1:0] VEC_UNUSED_LO = 16'h0026;
  localparam logic [VEC_W-1:0] VEC_UNUSED_HI = 16'h002C;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [NUM_SRC-1:0] MASK_RESET = 16'hFFFF;
  localparam logic [NUM_SRC-1:0] PEND_RESET = 16'h0000;
  localparam logic ACCEPT_RESET = 1'b0;

endpackage
`default_nettype wire

// ### hw/vipl_prio_pick.sv
// Fixed priority picker: lowest set index wins.
`timescale 1ns/10ps
`default_nettype none
module vipl_prio_pick
  import vipl_pkg::*;
(
  input wire logic [NUM_SRC-1:0] req_i,
  output logic hit_o,
  output logic [PRIO_W-1:0] idx_o
);

  always_comb begin
    hit_o = 1'b0;
    idx_o = 4'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        hit_o = 1'b1;
        idx_o = PRIO_W'(i);
      end
    end
  end

endmodule // vipl_prio_pick
`default_nettype wire

// ### tb/vipl_core_model.sv
// Processor core model that acknowledges offered requests and re-opens acceptance.
`timescale 1ns/10ps
`default_nettype none
module vipl_core_model (
  input wire logic clk_i,
  input wire logic en_i,
  input wire logic [3:0] stall_i,
  input wire logic nmi_i,
  input wire logic irq_i,
  output logic ack_o,
  output logic accept_set_o
);
  logic [3:0] wait_reg;
  logic was_irq_reg;
  initial begin
    ack_o = 1'b0;
    accept_set_o = 1'b0;
    wait_reg = '0;
    was_irq_reg = 1'b0;
  end
  // Acts on the falling edge so the device samples settled values.
  // Acceptance is re-opened one cycle after a maskable acknowledge, as a handler would.
  always @(negedge clk_i) begin
    accept_set_o <= ack_o && was_irq_reg;
    if (ack_o) begin
      ack_o <= 1'b0;
      wait_reg <= '0;
    end else if (en_i && (nmi_i || irq_i)) begin
      if (wait_reg >= stall_i) begin
        ack_o <= 1'b1;
        was_irq_reg <= irq_i;
      end else begin
        wait_reg <= wait_reg + 4'h1;
      end
    end
  end
endmodule // vipl_core_model
`default_nettype wire

// ### tb/vipl_tb_top.sv
// Self-checking testbench of the vectored interrupt priority logic.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_count++; \
  $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module vipl_tb_top;
  import vipl_pkg::*;
  logic clk = 1'b0, srst = 1'b1, mode = 1'b0, sera = 1'b0, mwr = 1'b0, tacc = 1'b0;
  logic tclr = 1'b0;
  logic en = 1'b0, ack, cacc, nmi, irq, stby, gacc;
  logic [3:0] stall = 4'h0, prio;
  logic [15:0] src = '0, mdat = '0, pclr = '0, vec, pend, mask;
  logic [19:0] e;
  logic [19:0] expq[$];
  int err_count = 0, n_tests = 0, r;
  always #5 clk = ~clk;
  vipl_top vipl_top_i (.CLK_I(clk), .SRST_I(srst), .WDT_INTERVAL_MODE_I(mode),
    .WATCHDOG_OVERFLOW_IRQ_I(src[0]), .PIN_EDGE_IRQ_0_I(src[1]), .PIN_EDGE_IRQ_1_I(src[2]),
    .PIN_EDGE_IRQ_2_I(src[3]), .PIN_EDGE_IRQ_3_I(src[4]), .SERIAL_RX_DONE_IRQ_I(src[5]),
    .SERIAL_A_CLOCKED_XFER_IRQ_I(sera), .SERIAL_B_CLOCKED_XFER_IRQ_I(src[6]),
    .SERIAL_TX_DONE_IRQ_I(src[7]), .WATCH_INTERVAL_IRQ_I(src[8]), .TIMER_A_MATCH_IRQ_I(src[9]),
    .TIMER_B_MATCH_IRQ_I(src[10]), .TIMER_C_MATCH_IRQ_I(src[11]),
    .CONVERTER_DONE_IRQ_I(src[13]), .WATCH_OVERFLOW_IRQ_I(src[14]),
    .KEY_RETURN_IRQ_I(src[15]), .TIMER_D_MATCH_IRQ_I(src[12]), .MASK_WR_I(mwr),
    .MASK_DATA_I(mdat), .PEND_CLR_I(pclr), .ACCEPT_SET_I(tacc | cacc), .ACCEPT_CLR_I(tclr),
    .ACK_I(ack), .NMI_REQ_O(nmi), .IRQ_REQ_O(irq), .VECTOR_O(vec), .PRIORITY_O(prio),
    .STBY_RELEASE_O(stby), .PENDING_O(pend), .SOURCE_MASK_FLAG_O(mask),
    .GLOBAL_ACCEPT_FLAG_O(gacc));
  vipl_core_model vipl_core_model_i (.clk_i(clk), .en_i(en), .stall_i(stall), .nmi_i(nmi),
    .irq_i(irq), .ack_o(ack), .accept_set_o(cacc));
  // Expected vector of a maskable level, with the hole at 000EH skipped.
  function automatic logic [15:0] vexp(int i);
    return (i == 0) ? 16'h0004 : ((i < 5) ? 16'(4 + 2 * i) : 16'(6 + 2 * i));
  endfunction
  // Every accepted acknowledge must carry the oldest expected vector.
  always @(posedge clk) begin
    if (ack === 1'b1 && (nmi === 1'b1 || irq === 1'b1)) begin
      if (expq.size() == 0) begin
        `CHK("unexpected ack", 16'hFFFF, vec)
      end else begin
        e = expq.pop_front();
        `CHK("vector", e[15:0], vec)
        if (irq === 1'b1) begin
          `CHK("priority", e[19:16], prio)
        end
      end
    end
  end
  task automatic pulse(input logic [15:0] m, input logic sa);
    @(negedge clk);
    src = m;
    sera = sa;
    @(negedge clk);
    src = '0;
    sera = 1'b0;
  endtask
  task automatic drain();
    int k;
    k = 0;
    while (expq.size() != 0 && k < 300) begin
      @(negedge clk);
      k++;
    end
    `CHK("queue left", 0, expq.size())
  endtask
  task automatic summarize();
    if (err_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    summarize();
  end
  initial begin
    void'($urandom(6873));
    repeat (20) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    `CHK("mask reset", 16'hFFFF, mask)
    `CHK("pend reset", 16'h0000, pend)
    `CHK("accept reset", 1'b0, gacc)
    // Masked source is held pending but not offered and does not wake the core.
    pulse(16'h0008, 1'b0);
    `CHK("masked pend", 1'b1, pend[3])
    `CHK("masked irq", 1'b0, irq)
    `CHK("masked stby", 1'b0, stby)
    pclr = 16'h0008;
    @(negedge clk);
    pclr = '0;
    `CHK("sw clear", 1'b0, pend[3])
    // Non-maskable watchdog with all masked and acceptance closed.
    en = 1'b1;
    stall = 4'h2;
    expq.push_back({4'h0, 16'h0004});
    pulse(16'h0003, 1'b0);
    `CHK("nmi req", 1'b1, nmi)
    `CHK("nmi stby", 1'b1, stby)
    `CHK("wdt not maskable", 1'b0, pend[0])
    drain();
    pclr = 16'h0002;
    @(negedge clk);
    pclr = '0;
    // Interval mode, all unmasked: random simultaneous sets served lowest level first.
    mode = 1'b1;
    mwr = 1'b1;
    mdat = '0;
    tacc = 1'b1;
    @(negedge clk);
    mwr = 1'b0;
    tacc = 1'b0;
    for (int n = 0; n < 8; n++) begin
      stall = 4'(n);
      r = $urandom & 32'h0000_FFFF;
      if (n == 0) begin
        r = 32'h0000_FFFF;
      end
      for (int i = 0; i < 16; i++) begin
        if (r[i]) begin
          expq.push_back({4'(i), vexp(i)});
        end
      end
      pulse(16'(r) & ~(n[0] ? 16'h0020 : 16'h0000), r[5] & n[0]);
      if (r != 0) begin
        `CHK("stby", 1'b1, stby)
      end
      drain();
    end
    // Acceptance closed: an unmasked event waits and wakes the core, then is served.
    @(negedge clk);
    mdat = 16'h0004;
    mwr = 1'b1;
    tclr = 1'b1;
    @(negedge clk);
    mwr = 1'b0;
    tclr = 1'b0;
    pulse(16'h0006, 1'b0);
    `CHK("closed irq", 1'b0, irq)
    `CHK("closed stby", 1'b1, stby)
    `CHK("closed flag", 1'b0, gacc)
    `CHK("closed pend", 16'h0006, pend)
    expq.push_back({4'h1, 16'h0006});
    tacc = 1'b1;
    @(negedge clk);
    tacc = 1'b0;
    drain();
    `CHK("masked left", 16'h0004, pend)
    // A waiting watchdog in non-maskable form wins over a pending maskable.
    mode = 1'b0;
    expq.push_back({4'h0, 16'h0004});
    expq.push_back({4'hF, vexp(15)});
    pulse(16'h8001, 1'b0);
    drain();
    summarize();
  end
endmodule // vipl_tb_top
`default_nettype wire
